// file: src/serial_port_pkg.sv
// constants, types and helpers for the modem serial port
package serial_port_pkg;
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned OVERSAMPLE = 16;
   localparam int unsigned BUF_DEPTH = 2048;
   localparam int unsigned FLOW_MARGIN = 17;
   localparam logic [11:0] FLOW_THRESH_RST = 12'(BUF_DEPTH - FLOW_MARGIN);
   localparam logic [11:0] PKT_BYTES_RST = 12'h800;
   localparam logic [15:0] PKT_SILENCE_RST = 16'h0003;
   localparam logic [3:0] BAUD_RST = 4'h3;
   localparam logic [7:0] XOFF_CHAR = 8'h13;
   localparam logic [7:0] XON_CHAR = 8'h11;
   // register byte offsets
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_FLOW = 8'h04;
   localparam logic [7:0] OFS_PACKET = 8'h08;
   localparam logic [7:0] OFS_DIVISOR = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   // config and packet register field positions
   localparam int unsigned CFG_PAR_LSB = 4;
   localparam int unsigned CFG_STOP_BIT = 7;
   localparam int unsigned CFG_SOFT_BIT = 8;
   localparam int unsigned CFG_RTS_LSB = 9;
   localparam int unsigned CFG_CTS_LSB = 11;
   localparam int unsigned PKT_TMO_LSB = 16;
   typedef enum logic [2:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_MARK, PAR_SPACE} parity_t;
   localparam logic [1:0] RTS_IGNORE = 2'h0;
   localparam logic [1:0] RTS_BINARY = 2'h1;
   localparam logic [1:0] RTS_HW_FLOW = 2'h2;
   localparam logic [2:0] CTS_BUFFER = 3'h0;
   localparam logic [2:0] CTS_HIGH = 3'h2;
   localparam logic [2:0] CTS_LOW = 3'h4;
   typedef struct packed {
      logic [2:0] cts_mode;
      logic [1:0] rts_mode;
      logic soft_flow;
      logic two_stop;
      logic [2:0] parity;
      logic [3:0] baud;
   } cfg_t;
   localparam cfg_t CFG_RST = '{cts_mode: CTS_BUFFER, rts_mode: RTS_IGNORE, soft_flow: 1'b0,
      two_stop: 1'b0, parity: PAR_NONE, baud: BAUD_RST};
   // oversample tick divisor for a bit rate, rounded to nearest
   function automatic logic [17:0] rate_div(input int unsigned bps);
      rate_div = 18'((CLK_HZ + OVERSAMPLE * bps / 2) / (OVERSAMPLE * bps));
   endfunction
   function automatic logic [17:0] baud_div(input logic [3:0] code);
      unique case (code)
         4'h0: baud_div = rate_div(1200);
         4'h1: baud_div = rate_div(2400);
         4'h2: baud_div = rate_div(4800);
         4'h4: baud_div = rate_div(19200);
         4'h5: baud_div = rate_div(38400);
         4'h6: baud_div = rate_div(57600);
         4'h7: baud_div = rate_div(115200);
         4'h8: baud_div = rate_div(230400);
         default: baud_div = rate_div(9600);
      endcase
   endfunction
   // parity bit for a data byte under a parity mode
   function automatic logic par_bit(input logic [2:0] mode, input logic [7:0] d);
      unique case (mode)
         PAR_EVEN: par_bit = ^d;
         PAR_ODD: par_bit = ~^d;
         PAR_MARK: par_bit = 1'b1;
         default: par_bit = 1'b0;
      endcase
   endfunction
endpackage

// file: src/modem_serial_port.sv
// serial port with input buffer, flow control and packet trigger
`timescale 1ns/1ps
`default_nettype none
module modem_serial_port (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // terminal lines
   input wire logic txd_in,
   input wire logic rts_in,
   output logic rxd_out,
   output logic cts_out,
   output logic binary_cmd_sel,
   // buffered bytes toward the radio
   output logic pkt_start,
   output logic [7:0] pkt_data,
   output logic pkt_valid,
   input wire logic pkt_ready
);
   logic rst_s1_q, rst_n;
   always_ff @(posedge clock or negedge resetn)
      if (!resetn) {rst_n, rst_s1_q} <= 2'b00;
      else {rst_n, rst_s1_q} <= {rst_s1_q, 1'b1};

   // registers
   serial_port_pkg::cfg_t cfg_q;
   logic [11:0] flow_thresh_q, pkt_bytes_q;
   logic [15:0] pkt_tmo_q;
   logic [17:0] div_q;
   logic frame_err_q, par_err_q, overrun_q;

   // ahb address phase capture
   logic wr_q, rd_q;
   logic [7:0] addr_q;
   wire take = hsel && hready && htrans[1];
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         addr_q <= 8'h00;
      end
      else
      begin
         wr_q <= take && hwrite;
         rd_q <= take && !hwrite;
         addr_q <= {haddr[7:2], 2'b00};
      end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   logic [11:0] fill_q;
   logic pkt_active_q, xoff_sent_q;
   wire [11:0] thresh_clip = (hwdata[11:0] > serial_port_pkg::FLOW_THRESH_RST) ?
      serial_port_pkg::FLOW_THRESH_RST : hwdata[11:0];
   wire [11:0] bytes_clip = (hwdata[11:0] > serial_port_pkg::PKT_BYTES_RST) ?
      serial_port_pkg::PKT_BYTES_RST : hwdata[11:0];
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         cfg_q <= serial_port_pkg::CFG_RST;
         flow_thresh_q <= serial_port_pkg::FLOW_THRESH_RST;
         pkt_bytes_q <= serial_port_pkg::PKT_BYTES_RST;
         pkt_tmo_q <= serial_port_pkg::PKT_SILENCE_RST;
         div_q <= 18'h00000;
      end
      else if (wr_q)
      begin
         unique case (addr_q)
            serial_port_pkg::OFS_CONFIG: cfg_q <= hwdata[13:0];
            serial_port_pkg::OFS_FLOW: flow_thresh_q <= thresh_clip;
            serial_port_pkg::OFS_PACKET:
            begin
               pkt_bytes_q <= bytes_clip;
               pkt_tmo_q <= hwdata[serial_port_pkg::PKT_TMO_LSB +: 16];
            end
            serial_port_pkg::OFS_DIVISOR: div_q <= hwdata[17:0];
            default: ;
         endcase
      end

   wire rd_status = rd_q && addr_q == serial_port_pkg::OFS_STATUS;
   always_comb
   begin
      hrdata = 32'h00000000;
      if (rd_q)
      begin
         unique case (addr_q)
            serial_port_pkg::OFS_CONFIG: hrdata = {18'h00000, cfg_q};
            serial_port_pkg::OFS_FLOW: hrdata = {20'h00000, flow_thresh_q};
            serial_port_pkg::OFS_PACKET: hrdata = {pkt_tmo_q, 4'h0, pkt_bytes_q};
            serial_port_pkg::OFS_DIVISOR: hrdata = {14'h0000, div_q};
            serial_port_pkg::OFS_STATUS: hrdata = {14'h0000, xoff_sent_q, pkt_active_q,
               cts_out, overrun_q, par_err_q, frame_err_q, fill_q};
            default: hrdata = 32'h00000000;
         endcase
      end
   end

   // oversample tick
   logic [17:0] tick_cnt_q;
   wire [17:0] div_sel = (div_q != 18'h00000) ? div_q : serial_port_pkg::baud_div(cfg_q.baud);
   wire tick = tick_cnt_q >= div_sel - 18'h00001;
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n) tick_cnt_q <= 18'h00000;
      else tick_cnt_q <= tick ? 18'h00000 : tick_cnt_q + 18'h00001;

   // pin synchronisers
   logic [1:0] txd_s_q, rts_s_q;
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         txd_s_q <= 2'b11;
         rts_s_q <= 2'b00;
      end
      else
      begin
         txd_s_q <= {txd_s_q[0], txd_in};
         rts_s_q <= {rts_s_q[0], rts_in};
      end
   wire rx_pin = txd_s_q[1];
   assign binary_cmd_sel = cfg_q.rts_mode == serial_port_pkg::RTS_BINARY && rts_s_q[1];

   // receiver
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
   rx_state_t rx_q;
   logic [3:0] rx_ph_q;
   logic [2:0] rx_bit_q;
   logic [7:0] rx_sh_q;
   logic rx_push, rx_ok_q;
   wire has_par = cfg_q.parity != serial_port_pkg::PAR_NONE;
   wire mid = tick && rx_ph_q == 4'hF;
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         rx_q <= RX_IDLE;
         rx_ph_q <= 4'h0;
         rx_bit_q <= 3'h0;
         rx_sh_q <= 8'h00;
         rx_ok_q <= 1'b1;
      end
      else
      begin
         if (tick) rx_ph_q <= rx_ph_q + 4'h1;
         unique case (rx_q)
            RX_IDLE:
               if (!rx_pin)
               begin
                  rx_q <= RX_START;
                  rx_ph_q <= 4'h8;
                  // fresh parity verdict, so an old error is not reported again
                  rx_ok_q <= 1'b1;
               end
            RX_START:
               if (mid)
               begin
                  rx_q <= rx_pin ? RX_IDLE : RX_DATA;
                  rx_bit_q <= 3'h0;
               end
            RX_DATA:
               if (mid)
               begin
                  rx_sh_q <= {rx_pin, rx_sh_q[7:1]};
                  rx_bit_q <= rx_bit_q + 3'h1;
                  if (rx_bit_q == 3'h7) rx_q <= has_par ? RX_PAR : RX_STOP;
               end
            RX_PAR:
               if (mid)
               begin
                  rx_ok_q <= rx_pin == serial_port_pkg::par_bit(cfg_q.parity, rx_sh_q);
                  rx_q <= RX_STOP;
               end
            RX_STOP:
               if (mid) rx_q <= RX_IDLE;
            default: rx_q <= RX_IDLE;
         endcase
      end
   wire rx_done = rx_q == RX_STOP && mid;
   assign rx_push = rx_done && rx_pin;

   // input buffer
   logic [7:0] mem [0:serial_port_pkg::BUF_DEPTH-1];
   logic [10:0] wr_ptr_q, rd_ptr_q;
   wire full = fill_q == 12'(serial_port_pkg::BUF_DEPTH);
   wire empty = fill_q == 12'h000;
   wire do_wr = rx_push && !full;
   wire do_rd = pkt_active_q && !empty && (!pkt_valid || pkt_ready);
   always_ff @(posedge clock)
      if (do_wr) mem[wr_ptr_q] <= rx_sh_q;
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         wr_ptr_q <= 11'h000;
         rd_ptr_q <= 11'h000;
         fill_q <= 12'h000;
         pkt_data <= 8'h00;
         pkt_valid <= 1'b0;
         frame_err_q <= 1'b0;
         par_err_q <= 1'b0;
         overrun_q <= 1'b0;
      end
      else
      begin
         if (do_wr) wr_ptr_q <= wr_ptr_q + 11'h001;
         if (do_rd)
         begin
            rd_ptr_q <= rd_ptr_q + 11'h001;
            pkt_data <= mem[rd_ptr_q];
         end
         if (do_rd) pkt_valid <= 1'b1;
         else if (pkt_ready) pkt_valid <= 1'b0;
         fill_q <= fill_q + {11'h000, do_wr} - {11'h000, do_rd};
         // sticky error flags, set wins over read-clear
         frame_err_q <= (rx_done && !rx_pin) || (frame_err_q && !rd_status);
         par_err_q <= (rx_done && !rx_ok_q) || (par_err_q && !rd_status);
         overrun_q <= (rx_push && full) || (overrun_q && !rd_status);
      end

   // flow control
   wire at_limit = fill_q >= flow_thresh_q;
   always_comb
   begin
      unique case (cfg_q.cts_mode)
         serial_port_pkg::CTS_HIGH: cts_out = 1'b1;
         serial_port_pkg::CTS_LOW: cts_out = 1'b0;
         default: cts_out = !at_limit;
      endcase
   end

   // transmitter, carries flow characters to the terminal
   typedef enum logic {TX_IDLE, TX_RUN} tx_state_t;
   tx_state_t tx_q;
   logic [11:0] tx_sh_q;
   logic [3:0] tx_left_q, tx_ph_q;
   logic tx_xoff_q;
   wire want_xoff = cfg_q.soft_flow && at_limit && !xoff_sent_q;
   wire want_xon = xoff_sent_q && (!at_limit || !cfg_q.soft_flow);
   wire tx_hold = cfg_q.rts_mode == serial_port_pkg::RTS_HW_FLOW && !rts_s_q[1];
   wire tx_go = tx_q == TX_IDLE && (want_xoff || want_xon) && !tx_hold;
   wire [7:0] tx_byte = want_xoff ? serial_port_pkg::XOFF_CHAR : serial_port_pkg::XON_CHAR;
   wire tx_pb = serial_port_pkg::par_bit(cfg_q.parity, tx_byte);
   wire [11:0] frame = has_par ? {2'b11, tx_pb, tx_byte, 1'b0} : {3'b111, tx_byte, 1'b0};
   wire [3:0] frame_bits = 4'd10 + {3'h0, has_par} + {3'h0, cfg_q.two_stop};
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         tx_q <= TX_IDLE;
         tx_sh_q <= 12'hFFF;
         tx_left_q <= 4'h0;
         tx_ph_q <= 4'h0;
         tx_xoff_q <= 1'b0;
         xoff_sent_q <= 1'b0;
         rxd_out <= 1'b1;
      end
      else
      begin
         unique case (tx_q)
            TX_IDLE:
               if (tx_go)
               begin
                  tx_q <= TX_RUN;
                  tx_sh_q <= frame;
                  tx_left_q <= frame_bits;
                  tx_ph_q <= 4'h0;
                  tx_xoff_q <= want_xoff;
               end
            TX_RUN:
               if (tick)
               begin
                  tx_ph_q <= tx_ph_q + 4'h1;
                  if (tx_ph_q == 4'h0)
                  begin
                     rxd_out <= tx_sh_q[0];
                     tx_sh_q <= {1'b1, tx_sh_q[11:1]};
                  end
                  if (tx_ph_q == 4'hF)
                  begin
                     tx_left_q <= tx_left_q - 4'h1;
                     if (tx_left_q == 4'h1)
                     begin
                        tx_q <= TX_IDLE;
                        xoff_sent_q <= tx_xoff_q;
                     end
                  end
               end
            default: tx_q <= TX_IDLE;
         endcase
      end

   // packet trigger
   logic [9:0] char_tick_q;
   logic [15:0] silence_q;
   wire [9:0] char_ticks = {2'b00, frame_bits, 4'h0};
   wire rx_idle = rx_q == RX_IDLE && rx_pin;
   wire by_bytes = fill_q > pkt_bytes_q;
   wire by_silence = pkt_tmo_q != 16'h0000 && !empty && silence_q >= pkt_tmo_q;
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         char_tick_q <= 10'h000;
         silence_q <= 16'h0000;
         pkt_active_q <= 1'b0;
         pkt_start <= 1'b0;
      end
      else
      begin
         if (!rx_idle || rx_push)
         begin
            char_tick_q <= 10'h000;
            if (rx_push) silence_q <= 16'h0000;
         end
         else if (tick)
         begin
            if (char_tick_q >= char_ticks - 10'h001)
            begin
               char_tick_q <= 10'h000;
               if (silence_q != 16'hFFFF) silence_q <= silence_q + 16'h0001;
            end
            else char_tick_q <= char_tick_q + 10'h001;
         end
         pkt_start <= !pkt_active_q && (by_bytes || by_silence);
         if (!pkt_active_q && (by_bytes || by_silence)) pkt_active_q <= 1'b1;
         else if (empty && !pkt_valid) pkt_active_q <= 1'b0;
      end
endmodule // modem_serial_port
`default_nettype wire

// file: verification/serial_port_monitor.sv
// assertion checker for the modem serial port
`timescale 1ns/1ps
`default_nettype none
module serial_port_monitor (
   // clock, reset and bus
   input wire logic clock,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   // terminal lines and packet stream
   input wire logic rts_in,
   input wire logic rxd_out,
   input wire logic cts_out,
   input wire logic binary_cmd_sel,
   input wire logic pkt_start,
   input wire logic [7:0] pkt_data,
   input wire logic pkt_valid,
   input wire logic pkt_ready
);
   logic cw_q;
   serial_port_pkg::cfg_t cfg_q;
   // shadow of the configuration word
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         cw_q <= 1'b0;
         cfg_q <= serial_port_pkg::CFG_RST;
      end
      else
      begin
         cw_q <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == serial_port_pkg::OFS_CONFIG;
         if (cw_q)
            cfg_q <= serial_port_pkg::cfg_t'(hwdata[13:0]);
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   chk_cts_forced_high: assert property (cfg_q.cts_mode == serial_port_pkg::CTS_HIGH |-> cts_out)
      else $error("clear line low in forced high mode");
   chk_cts_forced_low: assert property (cfg_q.cts_mode == serial_port_pkg::CTS_LOW |-> !cts_out)
      else $error("clear line high in forced low mode");
   chk_binary_sel_mode: assert property (binary_cmd_sel |-> cfg_q.rts_mode == serial_port_pkg::RTS_BINARY
      && ($past(rts_in, 2) || $past(rts_in, 3) || $past(rts_in, 4)))
      else $error("binary select without mode or request");
   chk_start_bit_low: assert property ($fell(rxd_out) |=> !rxd_out [*7])
      else $error("start bit shorter than a bit time");
   chk_bit_level_hold: assert property ($rose(rxd_out) |=> rxd_out [*7])
      else $error("high bit shorter than a bit time");
   chk_start_pulse_valid: assert property (pkt_start |=> !pkt_start && pkt_valid)
      else $error("packet start not a pulse followed by data");
   chk_valid_after_start: assert property ($rose(pkt_valid) |-> $past(pkt_start))
      else $error("packet data without packet start");
   chk_pkt_data_hold: assert property (pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_data))
      else $error("buffered byte dropped before acceptance");
endmodule // serial_port_monitor
bind modem_serial_port serial_port_monitor u_serial_port_monitor (.clock(clock), .resetn(resetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .rts_in(rts_in), .rxd_out(rxd_out), .cts_out(cts_out), .binary_cmd_sel(binary_cmd_sel),
   .pkt_start(pkt_start), .pkt_data(pkt_data), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready));
`default_nettype wire

// file: verification/terminal_model.sv
// terminal model driving and watching the serial lines
`timescale 1ns/1ps
`default_nettype none
module terminal_model (
   // clock
   input wire logic clock,
   // serial lines
   input wire logic rxd,
   output logic txd
);
   int bit_clks = 112;
   int rx_count = 0;
   int rx_low;
   logic [8:0] rx_bits;
   initial txd = 1'b1;
   // one frame: start, data, optional parity, stop
   task automatic send(input logic [7:0] d, input logic pe, input logic pb, input logic sb);
      logic [10:0] f;
      f = {sb, pb, d, 1'b0};
      for (int i = 0; i < 11; i++)
      begin
         if (i != 9 || pe)
         begin
            txd <= f[i];
            repeat (bit_clks) @(posedge clock);
         end
      end
      txd <= 1'b1;
   endtask
   // capture start width and nine bits at their centres
   always
   begin
      @(negedge rxd);
      rx_low = 0;
      for (int i = 1; i <= bit_clks * 10; i++)
      begin
         @(posedge clock);
         if (i == rx_low + 1 && !rxd)
            rx_low = i;
         if (i > bit_clks && i % bit_clks == bit_clks / 2)
            rx_bits[i / bit_clks - 1] = rxd;
      end
      rx_count++;
   end
endmodule // terminal_model
`default_nettype wire

// file: verification/tb.sv
// self-checking bench for the modem serial port
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clock, resetn, hsel, hwrite, hreadyout, hresp, txd_in, rts_in, rxd_out, cts_out;
   logic binary_cmd_sel, pkt_start, pkt_valid, pkt_ready;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] pkt_data;
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;
   modem_serial_port u_modem_serial_port (.clock(clock), .resetn(resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .txd_in(txd_in),
      .rts_in(rts_in), .rxd_out(rxd_out), .cts_out(cts_out), .binary_cmd_sel(binary_cmd_sel),
      .pkt_start(pkt_start), .pkt_data(pkt_data), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready));
   terminal_model u_terminal_model (.clock(clock), .rxd(rxd_out), .txd(txd_in));
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 95000)
      begin
         failures++;
         close_out();
      end
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= 32'(a);
      hwrite <= wr;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
      // let a write settle before the caller looks at outputs
      @(posedge clock);
   endtask
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      check(what, exp, rd);
   endtask
   task automatic await_rx(input int c);
      for (int n = 0; n < 20000 && u_terminal_model.rx_count <= c; n++)
         @(posedge clock);
   endtask
   task automatic t_reset();
      rdc("config", serial_port_pkg::OFS_CONFIG, 32'(serial_port_pkg::CFG_RST));
      rdc("flow", serial_port_pkg::OFS_FLOW, 32'(serial_port_pkg::FLOW_THRESH_RST));
      rdc("packet", serial_port_pkg::OFS_PACKET, {serial_port_pkg::PKT_SILENCE_RST, 4'h0,
         serial_port_pkg::PKT_BYTES_RST});
      rdc("unmapped", 8'h14, 32'h0);
      check("cts idle", 32'h1, 32'(cts_out));
      check("hresp okay", 32'h0, 32'(hresp));
      ahb(1'b1, serial_port_pkg::OFS_FLOW, 32'h0000_0FFF);
      rdc("flow clip", serial_port_pkg::OFS_FLOW, 32'(serial_port_pkg::FLOW_THRESH_RST));
   endtask
   task automatic t_rx();
      int n;
      pkt_ready <= 1'b1;
      ahb(1'b1, serial_port_pkg::OFS_CONFIG, 32'h0000_0008);
      u_terminal_model.send(8'hA5, 1'b0, 1'b0, 1'b1);
      for (n = 0; n < 9000 && pkt_start !== 1'b1; n++)
         @(posedge clock);
      check("silence", 32'h1, 32'(n > 3000 && n < 3700));
      @(posedge clock);
      check("pkt byte", {24'h1, 8'hA5}, {23'h0, pkt_valid, pkt_data});
   endtask
   task automatic t_parity();
      logic p;
      for (int m = 1; m <= 4; m++)
      begin
         p = (m == 2 || m == 3);
         ahb(1'b1, serial_port_pkg::OFS_CONFIG, 32'h8 | (32'(m) << 4));
         u_terminal_model.send(8'hCC, 1'b1, p, 1'b1);
         ahb(1'b0, serial_port_pkg::OFS_STATUS, 32'h0);
         check("parity ok", 32'h0, rd & 32'h2000);
         u_terminal_model.send(8'hCC, 1'b1, !p, 1'b1);
         ahb(1'b0, serial_port_pkg::OFS_STATUS, 32'h0);
         check("parity bad", 32'h2000, rd & 32'h2000);
      end
      ahb(1'b1, serial_port_pkg::OFS_CONFIG, 32'h0000_0008);
      u_terminal_model.send(8'hCC, 1'b0, 1'b0, 1'b0);
      ahb(1'b0, serial_port_pkg::OFS_STATUS, 32'h0);
      check("frame err", 32'h1000, rd & 32'h3000);
      // low stop bit looks like a new start; let that frame and its packet drain
      repeat (5000) @(posedge clock);
   endtask
   task automatic t_flow();
      int c;
      logic [31:0] cfg;
      for (int i = 0; i < 2; i++)
      begin
         cfg = i ? 32'h0000_0148 : 32'h0000_0138;
         pkt_ready <= 1'b0;
         ahb(1'b1, serial_port_pkg::OFS_DIVISOR, i ? 32'h5 : 32'h0);
         ahb(1'b1, serial_port_pkg::OFS_FLOW, 32'h1);
         ahb(1'b1, serial_port_pkg::OFS_CONFIG, cfg);
         u_terminal_model.bit_clks = i ? 80 : 112;
         c = u_terminal_model.rx_count;
         u_terminal_model.send(8'h5A, 1'b1, i == 0, 1'b1);
         await_rx(c);
         check("xoff", 32'({i == 0, serial_port_pkg::XOFF_CHAR}), 32'(u_terminal_model.rx_bits));
         check("bit len", i ? 32'd80 : 32'd112, 32'(u_terminal_model.rx_low));
         check("cts full", 32'h0, 32'(cts_out));
         ahb(1'b1, serial_port_pkg::OFS_CONFIG, cfg | 32'h1000);
         check("cts forced", 32'h1, 32'(cts_out));
         ahb(1'b1, serial_port_pkg::OFS_CONFIG, cfg);
         pkt_ready <= 1'b1;
         await_rx(c + 1);
         check("xon", 32'({i == 0, serial_port_pkg::XON_CHAR}), 32'(u_terminal_model.rx_bits));
         check("cts room", 32'h1, 32'(cts_out));
      end
   endtask
   task automatic t_lines();
      ahb(1'b1, serial_port_pkg::OFS_CONFIG, 32'h0000_2008);
      check("cts low", 32'h0, 32'(cts_out));
      ahb(1'b1, serial_port_pkg::OFS_CONFIG, 32'h0000_0208);
      rts_in <= 1'b1;
      repeat (4) @(posedge clock);
      check("bin sel", 32'h1, 32'(binary_cmd_sel));
      ahb(1'b1, serial_port_pkg::OFS_CONFIG, 32'h0000_0408);
      check("bin hw", 32'h0, 32'(binary_cmd_sel));
      ahb(1'b1, serial_port_pkg::OFS_CONFIG, 32'h0000_0008);
      check("bin off", 32'h0, 32'(binary_cmd_sel));
      rts_in <= 1'b0;
   endtask
   initial
   begin
      resetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      rts_in = 1'b0;
      pkt_ready = 1'b0;
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      repeat (3) @(posedge clock);
      t_reset();
      t_rx();
      t_parity();
      t_flow();
      t_lines();
      close_out();
   end
endmodule // tb
`default_nettype wire
